/* File: src/dpr_ctl.v */
// host-side driver for both ports of an asynchronous dual-port memory
`timescale 1ns/1ps
`default_nettype none
`include "dpr_ctl_regs.vh"
module dpr_ctl #(
   parameter DATA_W    = 8,  // word width, 1 to 144
   parameter ADDR_W    = 8,  // address width, 3 to 14
   parameter SLEEP_VAR = 0   // 1 drives the sleep variant pins
)(
   input  wire              clk,                   // 25 MHz clock
   input  wire              rst_n,                 // async reset
   input  wire [1:0]        req_valid,             // per port request
   input  wire [1:0]        req_write,             // 1 write, 0 read
   input  wire [2*ADDR_W-1:0] req_addr,            // {b,a} address
   input  wire [2*DATA_W-1:0] req_wdata,           // {b,a} write data
   output wire [1:0]        req_ready,             // idle, accepts
   output wire [1:0]        rsp_valid,             // read data pulse
   output wire [2*DATA_W-1:0] rsp_rdata,           // {b,a} read data
   output wire [1:0]        collision,             // refused collide
   output reg  [ADDR_W-1:0] port_a_addr,           // memory a address
   output reg  [DATA_W-1:0] port_a_write_data,     // memory a data in
   input  wire [DATA_W-1:0] port_a_read_data,      // memory a data out
   output reg               port_a_select_n,       // a select
   output reg               port_a_write_strobe_n, // a write strobe
   output reg               port_a_output_gate_n,  // a output gate
   output reg               port_a_sleep,          // a sleep
   output reg  [ADDR_W-1:0] port_b_addr,           // memory b address
   output reg  [DATA_W-1:0] port_b_write_data,     // memory b data in
   input  wire [DATA_W-1:0] port_b_read_data,      // memory b data out
   output reg               port_b_select_n,       // b select
   output reg               port_b_write_strobe_n, // b write strobe
   output reg               port_b_output_gate_n,  // b output gate
   output reg               port_b_sleep            // b sleep
);
   localparam integer RD_CYC_I = `DPR_READ_CYCLES;
   localparam integer WR_CYC_I = `DPR_WRITE_CYCLES;
   localparam integer SU_CYC_I = `DPR_SETUP_CYCLES;
   localparam integer HD_CYC_I = `DPR_HOLD_CYCLES;
   localparam [7:0]   RD_CYC   = RD_CYC_I[7:0];
   localparam [7:0]   WR_CYC   = WR_CYC_I[7:0];
   localparam [7:0]   SU_CYC   = SU_CYC_I[7:0];
   localparam [7:0]   HD_CYC   = HD_CYC_I[7:0];

   localparam [2:0]   ST_IDLE   = 3'h0;
   localparam [2:0]   ST_SETUP  = 3'h1;
   localparam [2:0]   ST_STROBE = 3'h2;
   localparam [2:0]   ST_HOLD   = 3'h3;
   localparam [2:0]   ST_READ   = 3'h4;

   reg rst_s1;
   reg rst_s2;
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rst_s1 <= 1'b0;
         rst_s2 <= 1'b0;
      end
      else
      begin
         rst_s1 <= 1'b1;
         rst_s2 <= rst_s1;
      end
   end

   // per-port state lives in the generate block; these gather it up
   wire [1:0]          busy_wr;    // port has a write under way
   wire [2*ADDR_W-1:0] cur_addr;   // {b,a} latched address
   wire [2*DATA_W-1:0] cur_wdat;   // {b,a} latched write data
   wire [1:0]          strobe_lo;  // strobe wanted low
   wire [1:0]          sel_n;      // select wanted, active low
   wire [ADDR_W-1:0]   req_addr_a;
   wire [ADDR_W-1:0]   req_addr_b;
   wire [1:0]          take_wr;    // write offered to an idle port
   wire [1:0]          clash;

   assign req_addr_a = req_addr[ADDR_W-1:0];
   assign req_addr_b = req_addr[2*ADDR_W-1:ADDR_W];
   assign take_wr    = req_valid & req_ready & req_write;

   // a new write to the address of a write under way on the other port collides
   assign clash[0] = take_wr[0] && busy_wr[1]
                     && cur_addr[2*ADDR_W-1:ADDR_W] == req_addr_a;
   // port a wins when both ports take a write to one address together
   assign clash[1] = take_wr[1]
                     && ((busy_wr[0] && cur_addr[ADDR_W-1:0] == req_addr_b)
                     || (take_wr[0] && !clash[0]
                         && req_addr_a == req_addr_b));

   genvar p;
   generate
      for (p = 0; p < 2; p = p + 1)
      begin : g_port
         reg  [2:0]        state;
         reg  [7:0]        cnt;
         reg               wr;
         reg  [ADDR_W-1:0] addr;
         reg  [DATA_W-1:0] wdat;
         reg               stb_lo;
         reg               hold_sel_n;
         reg               ready;
         reg               rvalid;
         reg               refused;
         reg  [DATA_W-1:0] rdata;
         wire [DATA_W-1:0] mem_rd;

         assign mem_rd = (p == 0) ? port_a_read_data : port_b_read_data;
         assign busy_wr[p]                    = (state != ST_IDLE) && wr;
         assign cur_addr[p*ADDR_W +: ADDR_W]  = addr;
         assign cur_wdat[p*DATA_W +: DATA_W]  = wdat;
         assign strobe_lo[p]                  = stb_lo;
         assign sel_n[p]                      = hold_sel_n;
         assign req_ready[p]                  = ready;
         assign rsp_valid[p]                  = rvalid;
         assign collision[p]                  = refused;
         assign rsp_rdata[p*DATA_W +: DATA_W] = rdata;

         always @(posedge clk or negedge rst_s2)
         begin
            if (!rst_s2)
            begin
               state      <= ST_IDLE;
               cnt        <= 8'h00;
               wr         <= 1'b0;
               addr       <= {ADDR_W{1'b0}};
               wdat       <= {DATA_W{1'b0}};
               stb_lo     <= 1'b0;
               hold_sel_n <= 1'b1;
               ready      <= 1'b0;
               rvalid     <= 1'b0;
               refused    <= 1'b0;
               rdata      <= {DATA_W{1'b0}};
            end
            else
            begin
               rvalid  <= 1'b0;
               refused <= 1'b0;
               case (state)
                  ST_IDLE:
                  begin
                     ready      <= 1'b1;
                     hold_sel_n <= 1'b1;
                     if (req_valid[p] && ready)
                     begin
                        ready <= 1'b0;
                        if (clash[p])
                           refused <= 1'b1;
                        else
                        begin
                           // address and data latched once, held stable
                           addr <= req_addr[p*ADDR_W +: ADDR_W];
                           wdat <= req_wdata[p*DATA_W +: DATA_W];
                           wr         <= req_write[p];
                           hold_sel_n <= 1'b0;
                           cnt        <= 8'h00;
                           state      <= req_write[p] ? ST_SETUP : ST_READ;
                        end
                     end
                  end
                  ST_READ:
                  begin
                     cnt <= cnt + 8'h01;
                     if (cnt >= RD_CYC)
                     begin
                        rdata  <= mem_rd;
                        rvalid <= 1'b1;
                        state  <= ST_IDLE;
                     end
                  end
                  ST_SETUP:
                  begin
                     cnt <= cnt + 8'h01;
                     if (cnt + 8'h01 >= SU_CYC)
                     begin
                        cnt    <= 8'h00;
                        stb_lo <= 1'b1;
                        state  <= ST_STROBE;
                     end
                  end
                  ST_STROBE:
                  begin
                     cnt <= cnt + 8'h01;
                     if (cnt + 8'h01 >= WR_CYC)
                     begin
                        cnt    <= 8'h00;
                        stb_lo <= 1'b0;
                        state  <= ST_HOLD;
                     end
                  end
                  ST_HOLD:
                  begin
                     cnt <= cnt + 8'h01;
                     if (cnt + 8'h01 >= HD_CYC)
                        state <= ST_IDLE;
                  end
                  default:
                     state <= ST_IDLE;
               endcase
            end
         end
      end
   endgenerate

   // pin registers; select and sleep never drop mid-write, avoiding
   always @(posedge clk or negedge rst_s2)
   begin
      if (!rst_s2)
      begin
         port_a_addr           <= {ADDR_W{1'b0}};
         port_a_write_data     <= {DATA_W{1'b0}};
         port_a_select_n       <= 1'b1;
         port_a_write_strobe_n <= 1'b1;
         port_a_output_gate_n  <= 1'b1;
         port_a_sleep          <= 1'b0;
         port_b_addr           <= {ADDR_W{1'b0}};
         port_b_write_data     <= {DATA_W{1'b0}};
         port_b_select_n       <= 1'b1;
         port_b_write_strobe_n <= 1'b1;
         port_b_output_gate_n  <= 1'b1;
         port_b_sleep          <= 1'b0;
      end
      else
      begin
         port_a_addr           <= cur_addr[ADDR_W-1:0];
         port_a_write_data     <= cur_wdat[DATA_W-1:0];
         port_a_write_strobe_n <= ~strobe_lo[0];
         port_a_select_n       <= SLEEP_VAR ? 1'b1 : sel_n[0];
         port_a_output_gate_n  <= SLEEP_VAR ? 1'b1 : sel_n[0];
         port_a_sleep          <= SLEEP_VAR ? sel_n[0] : 1'b0;
         port_b_addr           <= cur_addr[2*ADDR_W-1:ADDR_W];
         port_b_write_data     <= cur_wdat[2*DATA_W-1:DATA_W];
         port_b_write_strobe_n <= ~strobe_lo[1];
         port_b_select_n       <= SLEEP_VAR ? 1'b1 : sel_n[1];
         port_b_output_gate_n  <= SLEEP_VAR ? 1'b1 : sel_n[1];
         port_b_sleep          <= SLEEP_VAR ? sel_n[1] : 1'b0;
      end
   end
endmodule
`default_nettype wire

/* File: src/dpr_ctl_regs.vh */
// timing constants for the dual-port memory driver
`ifndef DPR_CTL_REGS_VH
`define DPR_CTL_REGS_VH
`define DPR_CLK_PERIOD_NS   40
// least read cycle, write pulse, setup and hold, in ns
`define DPR_READ_CYCLE_NS   40
`define DPR_WRITE_PULSE_NS  40
`define DPR_SETUP_NS        40
`define DPR_HOLD_NS         40
`define DPR_CYC_UP(ns) (((ns) + `DPR_CLK_PERIOD_NS - 1) / `DPR_CLK_PERIOD_NS)
`define DPR_READ_CYCLES   `DPR_CYC_UP(`DPR_READ_CYCLE_NS)
`define DPR_WRITE_CYCLES  `DPR_CYC_UP(`DPR_WRITE_PULSE_NS)
`define DPR_SETUP_CYCLES  `DPR_CYC_UP(`DPR_SETUP_NS)
`define DPR_HOLD_CYCLES   `DPR_CYC_UP(`DPR_HOLD_NS)
`endif

/* File: test/dpr_ctl_mem.sv */
// behavioural dual-port memory answering the driver
`timescale 1ns/1ps
`default_nettype none
module dpr_ctl_mem #(parameter DATA_W = 8, parameter ADDR_W = 4)(
   input wire logic [2*ADDR_W-1:0] addr,                 // {b,a}
   input wire logic [2*DATA_W-1:0] wdata,                // {b,a}
   input wire logic [1:0]          sel_n, we_n, gate_n, sleep, // per port
   output wire logic [2*DATA_W-1:0] rdata                // {b,a}
);
   logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
   for (genvar p = 0; p < 2; p++)
   begin : g_port
      wire logic [ADDR_W-1:0] ad = addr[p*ADDR_W +: ADDR_W];
      wire logic [ADDR_W-1:0] od = addr[(1-p)*ADDR_W +: ADDR_W];
      wire logic [DATA_W-1:0] wd = wdata[p*DATA_W +: DATA_W];
      wire logic [DATA_W-1:0] other = wdata[(1-p)*DATA_W +: DATA_W];
      // an unknown address reads back unknown through mem[ad]
      wire logic [DATA_W-1:0] val = !we_n[p] ? wd :
         (!we_n[1-p] && !sel_n[1-p] && od == ad) ? other : mem[ad];
      logic [DATA_W-1:0] hold;
      always @(posedge we_n[p])
         if (!sel_n[p] && !sleep[p]) mem[ad] = wd;
      // unknown address at the strobe fall spoils every word
      always @(negedge we_n[p])
         if ($isunknown(ad))
            for (int i = 0; i < (1 << ADDR_W); i++) mem[i] = 'x;
      // a write cut short spoils its word unless it already matched
      always @(posedge sel_n[p] or posedge sleep[p])
         if (!we_n[p] && mem[ad] !== wd) mem[ad] = 'x;
      always @* if (!sel_n[p]) hold = val;
      // released output shows the inverse so stale data never matches
      assign rdata[p*DATA_W +: DATA_W] = sleep[p] ? '0 :
         gate_n[p] ? ~hold : hold;
   end
endmodule
`default_nettype wire

/* File: test/dpr_ctl_monitor.sv */
// concurrent checks on the dual-port memory driver pins
`timescale 1ns/1ps
`default_nettype none
module dpr_ctl_monitor #(parameter ADDR_W = 8)(
   input wire logic              clk, rst_n, port_a_sleep,
   input wire logic              port_a_select_n, port_b_select_n,
   input wire logic              port_a_write_strobe_n, port_b_write_strobe_n,
   input wire logic              port_a_output_gate_n,
   input wire logic [1:0]        req_valid, req_write, req_ready, rsp_valid,
   input wire logic [ADDR_W-1:0] port_a_addr
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence a_wr; req_valid[0] && req_ready[0] && req_write[0]; endsequence
   sequence a_rd; req_valid[0] && req_ready[0] && !req_write[0]; endsequence
   sequence a_pulse; !port_a_write_strobe_n ##1 port_a_write_strobe_n;
   endsequence
   chk_write_pulse: assert property (a_wr |-> ##[1:3] a_pulse)
      else $error("no strobe pulse after write");
   chk_read_answer: assert property (a_rd |-> ##[3:4] rsp_valid[0])
      else $error("read answer missing");
   chk_read_quiet: assert property (a_rd |-> port_a_write_strobe_n [*4])
      else $error("strobe during read");
   chk_pulse_width: assert property ($fell(port_a_write_strobe_n)
      |=> $rose(port_a_write_strobe_n)) else $error("strobe width");
   chk_addr_hold: assert property (!port_a_write_strobe_n
      |-> $stable(port_a_addr) ##1 $stable(port_a_addr))
      else $error("address moved around strobe");
   chk_strobe_sel: assert property ((port_a_write_strobe_n
      || !port_a_select_n) && (port_b_write_strobe_n || !port_b_select_n))
      else $error("strobe without select");
   chk_gate_sel: assert property (port_a_output_gate_n == port_a_select_n)
      else $error("gate apart from select");
   chk_no_sleep: assert property (!port_a_sleep) else $error("sleep");
endmodule
bind dpr_ctl dpr_ctl_monitor #(.ADDR_W(ADDR_W)) dpr_ctl_monitor_inst (
   .clk(clk), .rst_n(rst_n), .port_a_sleep(port_a_sleep),
   .port_a_select_n(port_a_select_n), .port_b_select_n(port_b_select_n),
   .port_a_write_strobe_n(port_a_write_strobe_n),
   .port_b_write_strobe_n(port_b_write_strobe_n),
   .port_a_output_gate_n(port_a_output_gate_n), .req_valid(req_valid),
   .req_write(req_write), .req_ready(req_ready), .rsp_valid(rsp_valid),
   .port_a_addr(port_a_addr));
`default_nettype wire

/* File: test/dpr_ctl_test.sv */
// self-checking bench for the dual-port memory driver
`timescale 1ns/1ps
`default_nettype none
module dpr_ctl_test;
   localparam DW = 8;
   localparam AW = 4;
   logic clk, rst_n;
   logic [1:0] req_valid, req_write;
   wire [1:0] req_ready, rsp_valid, collision;
   wire [1:0] sel_n, we_n, gate_n, sleep;
   logic [2*AW-1:0] req_addr;
   logic [2*DW-1:0] req_wdata;
   wire [2*DW-1:0] rsp_rdata, rdata;
   wire [AW-1:0] a_addr, b_addr;
   wire [DW-1:0] a_wd, b_wd;
   logic [DW-1:0] ref_mem [0:15];
   logic [DW-1:0] q [2][$];
   logic [31:0] rs = 32'hE8EE1E48;
   int mismatches, n_tests, coll;
   dpr_ctl #(.DATA_W(DW), .ADDR_W(AW)) dpr_ctl_inst (.clk(clk), .rst_n(rst_n),
      .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
      .req_wdata(req_wdata), .req_ready(req_ready), .rsp_valid(rsp_valid),
      .rsp_rdata(rsp_rdata), .collision(collision), .port_a_addr(a_addr),
      .port_a_write_data(a_wd), .port_a_read_data(rdata[DW-1:0]),
      .port_a_select_n(sel_n[0]), .port_a_write_strobe_n(we_n[0]),
      .port_a_output_gate_n(gate_n[0]), .port_a_sleep(sleep[0]),
      .port_b_addr(b_addr), .port_b_write_data(b_wd),
      .port_b_read_data(rdata[2*DW-1:DW]), .port_b_select_n(sel_n[1]),
      .port_b_write_strobe_n(we_n[1]), .port_b_output_gate_n(gate_n[1]),
      .port_b_sleep(sleep[1]));
   dpr_ctl_mem #(.DATA_W(DW), .ADDR_W(AW)) dpr_ctl_mem_inst (
      .addr({b_addr, a_addr}), .wdata({b_wd, a_wd}), .sel_n(sel_n),
      .we_n(we_n), .gate_n(gate_n), .sleep(sleep), .rdata(rdata));
   initial
   begin
      clk = 0;
      forever #20 clk = ~clk;
   end
   function automatic logic [31:0] xs();
      rs ^= rs << 13;
      rs ^= rs >> 17;
      rs ^= rs << 5;
      return rs;
   endfunction
   task automatic check(input logic [DW-1:0] e, g);
      n_tests++;
      if (e !== g)
      begin
         mismatches++;
         $display("unexpected at %0t: exp %h got %h", $time, e, g);
      end
   endtask
   task automatic conclude(input int hung);
      mismatches += hung;
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // one request per port, held up to the edge at which ready is high
   task automatic issue(input int p, input logic wr,
                        input logic [AW-1:0] ad, input logic [DW-1:0] d);
      int n;
      n = 0;
      @(posedge clk);
      req_valid[p] <= 1'b1;
      req_write[p] <= wr;
      req_addr[p*AW +: AW] <= ad;
      req_wdata[p*DW +: DW] <= d;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (req_ready[p] !== 1'b1 && n < 60);
      req_valid[p] <= 1'b0;
      if (req_ready[p] !== 1'b1)
         conclude(1);
      else if (wr)
         ref_mem[ad] = d;
      else
         q[p].push_back(ref_mem[ad]);
   endtask
   always @(posedge clk)
      for (int p = 0; p < 2; p++)
      begin
         if (rsp_valid[p] === 1'b1)
            check(q[p].size() ? q[p].pop_front() : 8'h00,
                  rsp_rdata[p*DW +: DW]);
         if (collision[p] === 1'b1)
            coll++;
      end
   initial
   begin
      {req_valid, req_write, req_addr, req_wdata} = '0;
      {rst_n, mismatches, n_tests, coll} = '0;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 16; i++) issue(0, 1, AW'(i), DW'(xs()));
      for (int i = 15; i >= 0; i--) issue(1, 0, AW'(i), 8'h00);
      $display("fill and cross read done");
      for (int i = 0; i < 8; i++)
         fork
            issue(0, 0, AW'(xs() % 8), 8'h00);
            issue(1, 1, AW'(8 + xs() % 8), DW'(xs()));
         join
      $display("concurrent traffic done");
      fork
         issue(0, 1, 4'h3, 8'h5A);
         begin
            @(posedge clk);
            issue(1, 1, 4'h3, 8'hC3);
         end
      join
      ref_mem[3] = 8'h5A;
      issue(0, 0, 4'h3, 8'h00);
      repeat (8) @(posedge clk);
      fork
         issue(0, 1, 4'h5, 8'hA5);
         issue(1, 1, 4'h5, 8'h3C);
      join
      ref_mem[5] = 8'hA5;
      issue(0, 0, 4'h5, 8'h00);
      repeat (8) @(posedge clk);
      check(8'h02, DW'(coll));
      check(8'h00, DW'(q[0].size() + q[1].size()));
      $display("collision done");
      conclude(0);
   end
endmodule
`default_nettype wire
